// ===== logic/hdd_dma.sv
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module hdd_dma #(
  parameter int unsigned MEM_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output hdd_pkg::hdd_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire hdd_pkg::hdd_rx_in_t rx_in,
  output logic rx_ready,
  output hdd_pkg::hdd_tx_out_t tx_out,
  input wire logic tx_ready
);
  import hdd_pkg::*;

  localparam int IW = $clog2(MEM_DEPTH);

  if (MEM_DEPTH < 8) begin : g_depth_check
    $error("MEM_DEPTH must hold two descriptors of four words");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hdd_state_t st_q, st_d;
  logic dir_q, dir_d;
  logic [1:0] w_q, w_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [31:0] rx_base_q, rx_base_d, tx_base_q, tx_base_d;
  logic [31:0] cur_rx_q, cur_rx_d, cur_tx_q, cur_tx_d;
  logic rx_susp_q, rx_susp_d, tx_susp_q, tx_susp_d;
  logic [31:0] ptr_q, ptr_d;
  logic [11:0] rem_q, rem_d;
  logic wrap_q, wrap_d, txlast_q, txlast_d;
  logic in_frame_q, in_frame_d, dfs_q, dfs_d, dls_q, dls_d, err_q, err_d;
  hdd_rx_stat_t stat_q, stat_d;
  logic [15:0] frames_q, frames_d;
  hdd_mem_req_t mem_q, mem_d;
  logic rx_ready_q, rx_ready_d;
  hdd_tx_out_t tx_q, tx_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;

  logic [31:0] cur;
  logic [31:0] close_word;
  logic dm_we;
  logic [IW-1:0] dm_waddr, dm_raddr;
  logic [31:0] dm_rdata;
  logic csr_wr;

  assign cur = dir_q ? cur_tx_q : cur_rx_q;
  assign csr_wr = avs_write && !wait_q;
  assign dm_waddr = IW'({dir_q, w_q});
  assign dm_raddr = (st_q == S_LD1) ? IW'({dir_q, W_CTL}) :
                    (st_q == S_LD2) ? IW'({dir_q, W_BUF}) : IW'({dir_q, W_NEXT});

  hdd_desc_mem #(.WIDTH(32), .DEPTH(MEM_DEPTH)) u_desc_mem (
    .core_clk(core_clk),
    .reset(reset),
    .we(dm_we),
    .waddr(dm_waddr),
    .wdata(mem_rdata),
    .raddr(dm_raddr),
    .rdata_q(dm_rdata)
  );

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Status word written back on close
  // ----------------------------------------------------------------
  always_comb begin
    close_word = '0;
    close_word[OWN_BIT] = 1'b0;
    if (!dir_q) begin
      close_word[FS_BIT] = dfs_q;
      close_word[LS_BIT] = dls_q;
      if (dls_q) begin
        close_word[IPE_BIT] = stat_q.ip_err;
        close_word[TCP_SUM_FAULT_BIT] = stat_q.tcp_err;
        close_word[UDP_SUM_FAULT_BIT] = stat_q.udp_err;
        close_word[ES_BIT] = stat_q.crc_err | stat_q.too_long | stat_q.runt | err_q;
        close_word[FL_MSB:0] = stat_q.len;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    dir_d = dir_q;
    w_d = w_q;
    ctrl_d = ctrl_q;
    rx_base_d = rx_base_q;
    tx_base_d = tx_base_q;
    cur_rx_d = cur_rx_q;
    cur_tx_d = cur_tx_q;
    rx_susp_d = rx_susp_q;
    tx_susp_d = tx_susp_q;
    ptr_d = ptr_q;
    rem_d = rem_q;
    wrap_d = wrap_q;
    txlast_d = txlast_q;
    in_frame_d = in_frame_q;
    dfs_d = dfs_q;
    dls_d = dls_q;
    err_d = err_q;
    stat_d = stat_q;
    frames_d = frames_q;
    mem_d = mem_q;
    rx_ready_d = 1'b0;
    tx_d = tx_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    dm_we = 1'b0;

    // Bus slave: one wait cycle, then the answer
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = '0;
      if (avs_read) begin
        unique case (avs_address)
          REG_CTRL: rdata_d[2:0] = ctrl_q;
          REG_RX_BASE: rdata_d = rx_base_q;
          REG_TX_BASE: rdata_d = tx_base_q;
          REG_STATUS: begin
            rdata_d[STAT_RX_SUSP] = rx_susp_q;
            rdata_d[STAT_TX_SUSP] = tx_susp_q;
            rdata_d[STAT_BUSY] = (st_q != S_IDLE);
            rdata_d[STAT_CNT_LSB +: 16] = frames_q;
          end
          default: rdata_d = '0;
        endcase
      end
    end
    if (csr_wr) begin
      unique case (avs_address)
        REG_CTRL: if (avs_byteenable[0]) ctrl_d = avs_writedata[2:0];
        REG_RX_BASE: begin
          rx_base_d = be_merge(rx_base_q, avs_writedata, avs_byteenable);
          cur_rx_d = rx_base_d;
          rx_susp_d = 1'b0;
        end
        REG_TX_BASE: begin
          tx_base_d = be_merge(tx_base_q, avs_writedata, avs_byteenable);
          cur_tx_d = tx_base_d;
          tx_susp_d = 1'b0;
        end
        REG_POLL: if (avs_byteenable[0]) begin
          if (avs_writedata[POLL_RX]) rx_susp_d = 1'b0;
          if (avs_writedata[POLL_TX]) tx_susp_d = 1'b0;
        end
        default: ;
      endcase
    end

    // Descriptor engine; its suspend sets come after the clears and win
    unique case (st_q)
      S_IDLE: begin
        if (ctrl_q[CTRL_RX_EN] && !rx_susp_q && (in_frame_q || rx_in.valid)) begin
          dir_d = 1'b0;
          w_d = W_STAT;
          st_d = S_FETCH;
        end else if (ctrl_q[CTRL_TX_EN] && !tx_susp_q) begin
          dir_d = 1'b1;
          w_d = W_STAT;
          st_d = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          mem_d.req = 1'b0;
          dm_we = 1'b1;
          if (w_q == W_STAT && !mem_rdata[OWN_BIT]) begin
            if (dir_q) tx_susp_d = 1'b1;
            else rx_susp_d = 1'b1;
            st_d = S_IDLE;
          end else if (w_q == W_NEXT) begin
            st_d = S_LD1;
          end else begin
            if (w_q == W_STAT) txlast_d = mem_rdata[LS_BIT];
            w_d = w_q + 2'h1;
          end
        end else if (!mem_q.req) begin
          mem_d = '{req: 1'b1, we: 1'b0, addr: cur + 32'({w_q, 2'b00}), wdata: '0};
        end
      end
      S_LD1: st_d = S_LD2;
      S_LD2: begin
        rem_d = dm_rdata[SIZE_MSB:0];
        wrap_d = dm_rdata[WRAP_BIT];
        st_d = S_LD3;
      end
      S_LD3: begin
        ptr_d = dm_rdata;
        st_d = (rem_q[11:2] == '0) ? S_NX0 : S_MOVE;
      end
      S_MOVE: begin
        if (!dir_q) begin
          rx_ready_d = 1'b1;
          if (rx_in.valid && rx_ready_q) begin
            rx_ready_d = 1'b0;
            mem_d = '{req: 1'b1, we: 1'b1, addr: ptr_q, wdata: rx_in.data};
            if (!in_frame_q) begin
              in_frame_d = 1'b1;
              dfs_d = 1'b1;
            end
            dls_d = rx_in.last;
            stat_d = rx_in.stat;
            st_d = S_XFER;
          end
        end else if (rem_q[11:2] == '0) begin
          st_d = S_CLOSE;
        end else begin
          mem_d = '{req: 1'b1, we: 1'b0, addr: ptr_q, wdata: '0};
          st_d = S_XFER;
        end
      end
      S_XFER: begin
        if (mem_ack) begin
          mem_d.req = 1'b0;
          ptr_d = ptr_q + WORD_BYTES;
          rem_d = rem_q - SIZE_STEP;
          if (dir_q) begin
            tx_d = '{valid: 1'b1, last: txlast_q && rem_q[11:2] == ONE_WORD, data: mem_rdata};
            st_d = S_TXOUT;
          end else if (dls_q) begin
            st_d = S_CLOSE;
          end else if (rem_q[11:2] == ONE_WORD) begin
            if (ctrl_q[CTRL_CHAIN]) begin
              st_d = S_CLOSE;
            end else begin
              err_d = 1'b1;
              st_d = S_DROP;
            end
          end else begin
            st_d = S_MOVE;
          end
        end
      end
      S_TXOUT: begin
        if (tx_ready && tx_q.valid) begin
          tx_d.valid = 1'b0;
          tx_d.last = 1'b0;
          st_d = S_MOVE;
        end
      end
      S_DROP: begin
        rx_ready_d = 1'b1;
        if (rx_in.valid && rx_ready_q) begin
          rx_ready_d = 1'b0;
          if (rx_in.last) begin
            dls_d = 1'b1;
            stat_d = rx_in.stat;
            st_d = S_CLOSE;
          end
        end
      end
      S_CLOSE: begin
        if (mem_ack) begin
          mem_d.req = 1'b0;
          if (!dir_q && dls_q) begin
            frames_d = frames_q + 16'h0001;
            in_frame_d = 1'b0;
          end
          dfs_d = 1'b0;
          dls_d = 1'b0;
          err_d = 1'b0;
          st_d = S_NX0;
        end else if (!mem_q.req) begin
          mem_d = '{req: 1'b1, we: 1'b1, addr: cur, wdata: close_word};
        end
      end
      S_NX0: st_d = S_NX1;
      S_NX1: begin
        if (dir_q) cur_tx_d = wrap_q ? tx_base_q : dm_rdata;
        else cur_rx_d = wrap_q ? rx_base_q : dm_rdata;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= S_IDLE;
      dir_q <= 1'b0;
      w_q <= W_STAT;
      ctrl_q <= CTRL_RESET;
      rx_base_q <= '0;
      tx_base_q <= '0;
      cur_rx_q <= '0;
      cur_tx_q <= '0;
      rx_susp_q <= 1'b0;
      tx_susp_q <= 1'b0;
      ptr_q <= '0;
      rem_q <= '0;
      wrap_q <= 1'b0;
      txlast_q <= 1'b0;
      in_frame_q <= 1'b0;
      dfs_q <= 1'b0;
      dls_q <= 1'b0;
      err_q <= 1'b0;
      stat_q <= '0;
      frames_q <= '0;
      mem_q <= '0;
      rx_ready_q <= 1'b0;
      tx_q <= '0;
      rdata_q <= '0;
      wait_q <= 1'b1;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      w_q <= w_d;
      ctrl_q <= ctrl_d;
      rx_base_q <= rx_base_d;
      tx_base_q <= tx_base_d;
      cur_rx_q <= cur_rx_d;
      cur_tx_q <= cur_tx_d;
      rx_susp_q <= rx_susp_d;
      tx_susp_q <= tx_susp_d;
      ptr_q <= ptr_d;
      rem_q <= rem_d;
      wrap_q <= wrap_d;
      txlast_q <= txlast_d;
      in_frame_q <= in_frame_d;
      dfs_q <= dfs_d;
      dls_q <= dls_d;
      err_q <= err_d;
      stat_q <= stat_d;
      frames_q <= frames_d;
      mem_q <= mem_d;
      rx_ready_q <= rx_ready_d;
      tx_q <= tx_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign mem_req = mem_q;
  assign rx_ready = rx_ready_q;
  assign tx_out = tx_q;
endmodule

`default_nettype wire

// ===== logic/hdd_pkg.sv
package hdd_pkg;

  // ----------------------------------------------------------------
  // Register map, word index on the bus (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_RX_BASE = 3'h1;
  localparam logic [2:0] REG_TX_BASE = 3'h2;
  localparam logic [2:0] REG_POLL = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_CHAIN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam int POLL_RX = 0;
  localparam int POLL_TX = 1;
  localparam int STAT_RX_SUSP = 0;
  localparam int STAT_TX_SUSP = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_CNT_LSB = 16;

  // ----------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------
  localparam int OWN_BIT = 31;
  localparam int FS_BIT = 30;
  localparam int LS_BIT = 29;
  localparam int IPE_BIT = 28;
  localparam int TCP_SUM_FAULT_BIT = 27;
  localparam int UDP_SUM_FAULT_BIT = 26;
  localparam int ES_BIT = 25;
  localparam int WRAP_BIT = 25;
  localparam int SIZE_MSB = 11;
  localparam int FL_MSB = 10;
  localparam logic [1:0] W_STAT = 2'h0;
  localparam logic [1:0] W_CTL = 2'h1;
  localparam logic [1:0] W_BUF = 2'h2;
  localparam logic [1:0] W_NEXT = 2'h3;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [11:0] SIZE_STEP = 12'h004;
  localparam logic [9:0] ONE_WORD = 10'h001;

  typedef enum logic [11:0] {
    S_IDLE  = 12'h001,
    S_FETCH = 12'h002,
    S_LD1   = 12'h004,
    S_LD2   = 12'h008,
    S_LD3   = 12'h010,
    S_MOVE  = 12'h020,
    S_XFER  = 12'h040,
    S_TXOUT = 12'h080,
    S_DROP  = 12'h100,
    S_CLOSE = 12'h200,
    S_NX0   = 12'h400,
    S_NX1   = 12'h800
  } hdd_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hdd_mem_req_t;

  typedef struct packed {
    logic [10:0] len;
    logic crc_err;
    logic too_long;
    logic runt;
    logic ip_err;
    logic tcp_err;
    logic udp_err;
  } hdd_rx_stat_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
    hdd_rx_stat_t stat;
  } hdd_rx_in_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } hdd_tx_out_t;

endpackage

// ===== logic/hdd_desc_mem.sv
`timescale 1ns/1ps
`default_nettype none

module hdd_desc_mem #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

`default_nettype wire

// ===== testbench/hdd_dma_props.sv
`timescale 1ns/1ps
`default_nettype none

module hdd_dma_props
  import hdd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire hdd_pkg::hdd_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire hdd_pkg::hdd_rx_in_t rx_in,
  input wire logic rx_ready,
  input wire hdd_pkg::hdd_tx_out_t tx_out,
  input wire logic tx_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Port timing
  // ----------------------------------------------------------------
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
  a_hole_zero: assert property (
    !avs_waitrequest && avs_read && avs_address > 3'h4 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_mem_hold: assert property (
    mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr) && $stable(mem_req.we)
      && $stable(mem_req.wdata)) else $error("memory request changed before answer");
  a_mem_release: assert property (
    mem_req.req && mem_ack |=> !mem_req.req) else $error("memory request not released");
  a_mem_align: assert property (
    mem_req.req |-> mem_req.addr[1:0] == 2'h0) else $error("unaligned memory address");
  a_rx_take_drop: assert property (
    rx_in.valid && rx_ready |=> !rx_ready) else $error("ready stayed after take");
  a_rx_no_fetch: assert property (
    rx_ready |-> !mem_req.req) else $error("ready during memory access");
  a_tx_hold: assert property (
    tx_out.valid && !tx_ready |=> tx_out.valid && $stable(tx_out.data) && $stable(tx_out.last))
    else $error("transmit word changed while stalled");

  c_rx_last: cover property (rx_in.valid && rx_ready && rx_in.last);
  c_tx_last: cover property (tx_out.valid && tx_ready && tx_out.last);
  c_mem_write: cover property (mem_req.req && mem_ack && mem_req.we);
endmodule

bind hdd_dma hdd_dma_props u_props (
  .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mem_req(mem_req), .mem_ack(mem_ack), .rx_in(rx_in), .rx_ready(rx_ready),
  .tx_out(tx_out), .tx_ready(tx_ready)
);

`default_nettype wire

// ===== testbench/hdd_host_mem.sv
`timescale 1ns/1ps
`default_nettype none

module hdd_host_mem
  import hdd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire hdd_pkg::hdd_mem_req_t mem_req,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [1:0] cnt;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end

  // ----------------------------------------------------------------
  // Word memory, answer after lat idle cycles
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack) begin
        if (cnt == lat) begin
          mem_ack <= 1'b1;
          cnt <= 2'h0;
          if (mem_req.we) mem[mem_req.addr[9:2]] <= mem_req.wdata;
          else mem_rdata <= mem[mem_req.addr[9:2]];
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module tb;
  import hdd_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  hdd_mem_req_t mem_req;
  logic mem_ack;
  logic [31:0] mem_rdata;
  hdd_rx_in_t rx_in = '0;
  logic rx_ready;
  hdd_tx_out_t tx_out;
  logic tx_ready = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [32:0] txq[$];
  logic [31:0] q;
  logic [31:0] d [3];
  hdd_rx_stat_t st;
  int miscompares = 0;
  int n_checks = 0;

  always #20 core_clk = ~core_clk;

  hdd_dma u_hdd_dma (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_in(rx_in),
    .rx_ready(rx_ready), .tx_out(tx_out), .tx_ready(tx_ready));
  hdd_host_mem u_hdd_host_mem (.core_clk(core_clk), .reset(reset), .mem_req(mem_req),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always @(posedge core_clk) begin
    tx_ready <= 1'($urandom_range(0, 1));
    if (tx_out.valid === 1'b1 && tx_ready === 1'b1) txq.push_back({tx_out.last, tx_out.data});
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop();
  endtask

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) hang();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] peek(input logic [31:0] a);
    return u_hdd_host_mem.mem[a[9:2]];
  endfunction

  task automatic desc(input logic [31:0] a, input logic [31:0] w0, input logic [31:0] w1,
                      input logic [31:0] w2, input logic [31:0] w3);
    u_hdd_host_mem.mem[a[9:2] + 8'h1] = w1;
    u_hdd_host_mem.mem[a[9:2] + 8'h2] = w2;
    u_hdd_host_mem.mem[a[9:2] + 8'h3] = w3;
    u_hdd_host_mem.mem[a[9:2]] = w0;
  endtask

  task automatic wait_own(input logic [31:0] a);
    logic [31:0] w;
    w = peek(a);
    for (int n = 0; n < 400 && w[OWN_BIT] !== 1'b0; n++) begin
      @(posedge core_clk);
      w = peek(a);
    end
    if (w[OWN_BIT] !== 1'b0) hang();
  endtask

  task automatic fill(input int n);
    for (int i = 0; i < n; i++) d[i] = $urandom;
    st = 17'($urandom);
    lat <= 2'($urandom);
  endtask

  task automatic frame(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      rx_in.valid <= 1'b1;
      rx_in.data <= d[i];
      rx_in.last <= (i == n - 1);
      rx_in.stat <= st;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (rx_ready !== 1'b1 && k < 200);
      if (rx_ready !== 1'b1) hang();
    end
    rx_in.valid <= 1'b0;
    rx_in.data <= ~d[n - 1];
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] exp_w0(input logic fs, input logic ls, input hdd_rx_stat_t s);
    logic [31:0] w;
    w = 32'h0;
    w[FS_BIT] = fs;
    w[LS_BIT] = ls;
    w[IPE_BIT] = s.ip_err;
    w[TCP_SUM_FAULT_BIT] = s.tcp_err;
    w[UDP_SUM_FAULT_BIT] = s.udp_err;
    w[ES_BIT] = s.crc_err | s.too_long | s.runt;
    w[FL_MSB:0] = s.len;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hc3e9d573));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 3'(a), 32'h0, q);
      `CHK(q, (a == 0) ? 32'h0000_0004 : 32'h0000_0000)
    end
    fill(1);
    bus(1'b1, REG_RX_BASE, d[0] & 32'hFFFF_FFFC, q);
    bus(1'b0, REG_RX_BASE, 32'h0, q);
    `CHK(q, d[0] & 32'hFFFF_FFFC)
    bus(1'b1, 3'h6, 32'hFFFF_FFFF, q);
    bus(1'b0, 3'h6, 32'h0, q);
    `CHK(q, 32'h0)
    desc(32'h100, 32'h8000_0000, 32'h0000_0008, 32'h200, 32'h110);
    desc(32'h110, 32'h8000_0000, 32'h0200_0010, 32'h240, 32'h3F0);
    bus(1'b1, REG_RX_BASE, 32'h100, q);
    bus(1'b1, REG_CTRL, 32'h5, q);
    fill(3);
    frame(3);
    wait_own(32'h110);
    `CHK(peek(32'h100) & 32'hE000_0000, 32'h4000_0000)
    `CHK(peek(32'h110), exp_w0(1'b0, 1'b1, st))
    `CHK(peek(32'h200), d[0])
    `CHK(peek(32'h204), d[1])
    `CHK(peek(32'h240), d[2])
    bus(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[31:16], 16'h0001)
    fill(2);
    rx_in.valid <= 1'b1;
    rx_in.data <= d[0];
    rx_in.last <= 1'b0;
    rx_in.stat <= st;
    repeat (40) begin
      @(posedge core_clk);
      `CHK(rx_ready, 1'b0)
    end
    bus(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[STAT_RX_SUSP], 1'b1)
    desc(32'h100, 32'h8000_0000, 32'h0000_0000, 32'h200, 32'h110);
    desc(32'h110, 32'h8000_0000, 32'h0200_0010, 32'h240, 32'h3F0);
    bus(1'b1, REG_POLL, 32'h1, q);
    frame(2);
    wait_own(32'h110);
    `CHK(peek(32'h100), 32'h8000_0000)
    `CHK(peek(32'h110), exp_w0(1'b1, 1'b1, st))
    `CHK(peek(32'h240), d[0])
    `CHK(peek(32'h244), d[1])
    fill(2);
    desc(32'h180, 32'hA000_0000, 32'h0200_0008, 32'h280, 32'h3F0);
    u_hdd_host_mem.mem[8'hA0] = d[0];
    u_hdd_host_mem.mem[8'hA1] = d[1];
    bus(1'b1, REG_TX_BASE, 32'h180, q);
    bus(1'b1, REG_CTRL, 32'h7, q);
    for (int n = 0; n < 400 && txq.size() < 2; n++) @(posedge core_clk);
    if (txq.size() < 2) hang();
    `CHK(txq[0], {1'b0, d[0]})
    `CHK(txq[1], {1'b1, d[1]})
    wait_own(32'h180);
    `CHK(peek(32'h180), 32'h0)
    repeat (40) @(posedge core_clk);
    bus(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[STAT_TX_SUSP], 1'b1)
    desc(32'h100, 32'h8000_0000, 32'h0200_0004, 32'h200, 32'h3F0);
    u_hdd_host_mem.mem[8'h81] = 32'h0;
    bus(1'b1, REG_CTRL, 32'h1, q);
    fill(2);
    frame(2);
    wait_own(32'h100);
    `CHK(peek(32'h100), exp_w0(1'b1, 1'b1, st) | (32'h1 << ES_BIT))
    `CHK(peek(32'h200), d[0])
    `CHK(peek(32'h204), 32'h0)
    report_and_stop();
  end
endmodule

`default_nettype wire
